// ==== hw/rcal_pkg.sv ====
// Purpose: Constants, register map and BCD helpers for the RTC calendar.
// Assumes: 32-bit APB words; registers are 8 bits wide in the low byte.
// Notes:   Calendar and alarm values are BCD.
// Contract
// - Day counter BCD 01-31, steps per day carry
// - Calendar counters untouched by any reset
// - Day rollover limit follows month and leap year
// - Month BCD in bits 4:0, steps on day carry
// - Year two BCD digits, steps on month carry
// - Leap year when year divides by four
// - Day tens in 5:4, bits 7:6 read zero
// - Bit 7 of each alarm enables its compare
// - Alarm needs all enabled fields to match
// - Power-on reset clears every alarm enable
// - Alarm value fields never reset
// - Weekday alarm in bits 2:0, 6:3 zero
// - Match sets flag; write 0 clears it
// - Interrupt requested while flag and enable set
package rcal_pkg;
  localparam int unsigned NUM_ALM = 5;       // Seconds..day-of-month
  // Register byte offsets
  localparam logic [7:0] OFS_DAY  = 8'h00;
  localparam logic [7:0] OFS_MON  = 8'h04;
  localparam logic [7:0] OFS_YEAR = 8'h08;
  localparam logic [7:0] OFS_ALM0 = 8'h0C;  // Alarms at 0C,10,14,18,1C
  localparam logic [7:0] OFS_CTRL = 8'h20;
  // Decoded register indices
  localparam logic [3:0] IDX_DAY  = 4'h0;
  localparam logic [3:0] IDX_MON  = 4'h1;
  localparam logic [3:0] IDX_YEAR = 4'h2;
  localparam logic [3:0] IDX_ALM0 = 4'h3;
  localparam logic [3:0] IDX_CTRL = 4'h8;
  localparam logic [3:0] IDX_NONE = 4'hF;
  // Field positions and masks
  localparam int unsigned ENB_BIT = 7;
  localparam int unsigned AF_BIT  = 0;
  localparam int unsigned AIE_BIT = 3;
  localparam logic [7:0] DAY_MASK = 8'h3F;
  localparam logic [7:0] MON_MASK = 8'h1F;
  localparam logic [6:0] ALM_MASK [NUM_ALM] =
    '{7'h7F, 7'h7F, 7'h3F, 7'h07, 7'h3F};
  // BCD limits
  localparam logic [7:0] DAY_FIRST = 8'h01;
  localparam logic [7:0] MON_FIRST = 8'h01;
  localparam logic [7:0] MON_LAST  = 8'h12;
  localparam logic [7:0] YEAR_LAST = 8'h99;
  localparam logic [7:0] MON_FEB   = 8'h02;
  localparam logic [7:0] DAYS_28   = 8'h28;
  localparam logic [7:0] DAYS_29   = 8'h29;
  localparam logic [7:0] DAYS_30   = 8'h30;
  localparam logic [7:0] DAYS_31   = 8'h31;
  // Reset values
  localparam logic             CTRL_RST = 1'b0;
  localparam logic [NUM_ALM-1:0] ENB_RST = 5'h00;

  // Next BCD value of a two-digit number
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction : bcd_inc

  // Year value divisible by four; 00 counts as leap
  function automatic logic is_leap(input logic [7:0] y);
    logic [4:0] s;
    s = {y[7:4], 1'b0} + {1'b0, y[3:0]};
    is_leap = (s[1:0] == 2'h0);
  endfunction : is_leap

  // Last valid day of a month
  function automatic logic [7:0] last_day(input logic [7:0] m,
                                          input logic       leap);
    if (m == MON_FEB) begin
      last_day = leap ? DAYS_29 : DAYS_28;
    end else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) begin
      last_day = DAYS_30;
    end else begin
      last_day = DAYS_31;
    end
  endfunction : last_day
endpackage : rcal_pkg

// ==== hw/rcal_top.sv ====
// Purpose: Calendar counters and alarm compare behind an APB slave.
// Assumes: Time counters and day carry come from logic on clk_i.
// Notes:   Counters and alarm values hold through every reset.
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module rcal_top
  import rcal_pkg::*;
(
  input  wire logic        clk_i,        // 40 MHz clock
  input  wire logic        rst_i,        // Power-on reset, sync
  input  wire logic        ce_i,         // Clock enable
  input  wire logic        manual_rst_i, // Manual reset, sync
  input  wire logic        day_carry_i,  // Pulse from hours counter
  input  wire logic        count_run_i,  // Count-run level
  input  wire logic [7:0]  sec_cnt_i,    // Seconds counter, BCD
  input  wire logic [7:0]  min_cnt_i,    // Minutes counter, BCD
  input  wire logic [7:0]  hr_cnt_i,     // Hours counter, BCD
  input  wire logic [7:0]  wk_cnt_i,     // Weekday counter
  input  wire logic        psel_i,       // APB select
  input  wire logic        penable_i,    // APB enable
  input  wire logic        pwrite_i,     // APB direction
  input  wire logic [7:0]  paddr_i,      // APB byte address
  input  wire logic [31:0] pwdata_i,     // APB write data
  output var  logic        pready_o,     // APB ready
  output var  logic [31:0] prdata_o,     // APB read data
  output var  logic        pslverr_o,    // APB error
  output var  logic        alarm_flag_o, // Alarm match flag
  output var  logic        alarm_irq_o   // Alarm interrupt request
);

  logic [7:0]         day_cnt;
  logic [7:0]         mon_cnt;
  logic [7:0]         year_cnt;
  logic [6:0]         alm_val [NUM_ALM];
  logic [NUM_ALM-1:0] alm_enb;
  logic [7:0]         alm_cnt [NUM_ALM];
  logic [NUM_ALM-1:0] field_ok;
  logic               irq_enable;
  logic               match_prev;
  logic               match_now;
  logic               match_rise;
  logic               day_tick;
  logic               day_last;
  logic               mon_tick;
  logic               year_tick;
  logic               acc;
  logic               wr_go;
  logic [3:0]         widx;
  logic [7:0]         rd_byte;
  logic [2:0]         cal_set;

  // Map a byte address to a register index
  function automatic logic [3:0] decode(input logic [7:0] a);
    if (a == OFS_DAY) begin
      decode = IDX_DAY;
    end else if (a == OFS_MON) begin
      decode = IDX_MON;
    end else if (a == OFS_YEAR) begin
      decode = IDX_YEAR;
    end else if (a >= OFS_ALM0 && a < OFS_CTRL && a[1:0] == 2'h0) begin
      decode = IDX_ALM0 + 4'((a - OFS_ALM0) >> 2);
    end else if (a == OFS_CTRL) begin
      decode = IDX_CTRL;
    end else begin
      decode = IDX_NONE;
    end
  endfunction : decode

  // Bus phase decode
  assign widx  = decode(paddr_i);
  assign acc   = psel_i & penable_i;
  assign wr_go = ce_i & acc & pready_o & pwrite_i;

  // Carry chain: day, month, year
  assign day_tick  = day_carry_i & count_run_i;
  assign day_last  = day_cnt == last_day(mon_cnt, is_leap(year_cnt));
  assign mon_tick  = day_tick & day_last;
  assign year_tick = mon_tick & (mon_cnt == MON_LAST);

  // Day-of-month counter; no reset term at all
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (wr_go && widx == IDX_DAY) begin
        day_cnt <= pwdata_i[7:0] & DAY_MASK;
      end else if (mon_tick) begin
        day_cnt <= DAY_FIRST;
      end else if (day_tick) begin
        day_cnt <= bcd_inc(day_cnt);
      end
    end
  end

  // Month counter
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (wr_go && widx == IDX_MON) begin
        mon_cnt <= pwdata_i[7:0] & MON_MASK;
      end else if (year_tick) begin
        mon_cnt <= MON_FIRST;
      end else if (mon_tick) begin
        mon_cnt <= bcd_inc(mon_cnt);
      end
    end
  end

  // Year counter, wraps 99 to 00
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (wr_go && widx == IDX_YEAR) begin
        year_cnt <= pwdata_i[7:0];
      end else if (year_tick) begin
        year_cnt <= (year_cnt == YEAR_LAST) ? 8'h00
                                            : bcd_inc(year_cnt);
      end
    end
  end

  // Check helper: counters have no reset, so they are known once loaded
  always_ff @(posedge clk_i) begin
    if (wr_go && widx == IDX_DAY) begin
      cal_set[0] <= 1'b1;
    end
    if (wr_go && widx == IDX_MON) begin
      cal_set[1] <= 1'b1;
    end
    if (wr_go && widx == IDX_YEAR) begin
      cal_set[2] <= 1'b1;
    end
  end

  // Counters each alarm field compares with
  assign alm_cnt[0] = sec_cnt_i;
  assign alm_cnt[1] = min_cnt_i;
  assign alm_cnt[2] = hr_cnt_i;
  assign alm_cnt[3] = wk_cnt_i;
  assign alm_cnt[4] = day_cnt;

  // Alarm field storage and per-field compare
  for (genvar i = 0; i < NUM_ALM; i++) begin : g_alm
    // Value bits: no reset of any kind
    always_ff @(posedge clk_i) begin
      if (wr_go && widx == IDX_ALM0 + 4'(i)) begin
        alm_val[i] <= pwdata_i[6:0] & ALM_MASK[i];
      end
    end
    // Enable bit: cleared by power-on reset only
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        alm_enb[i] <= ENB_RST[i];
      end else if (wr_go && widx == IDX_ALM0 + 4'(i)) begin
        alm_enb[i] <= pwdata_i[ENB_BIT];
      end
    end
    assign field_ok[i] = ~alm_enb[i] |
                         ({1'b0, alm_val[i]} == alm_cnt[i]);
  end

  // Overall match needs at least one enabled field
  assign match_now  = (|alm_enb) & (&field_ok);
  assign match_rise = match_now & ~match_prev;

  // Edge memory so a cleared flag is not re-set within one match
  always_ff @(posedge clk_i) begin
    if (rst_i || manual_rst_i) begin
      match_prev <= CTRL_RST;
    end else if (ce_i) begin
      match_prev <= match_now;
    end
  end

  // Alarm flag: set wins over a clearing write
  always_ff @(posedge clk_i) begin
    if (rst_i || manual_rst_i) begin
      alarm_flag_o <= CTRL_RST;
    end else if (ce_i) begin
      if (match_rise) begin
        alarm_flag_o <= 1'b1;
      end else if (wr_go && widx == IDX_CTRL && !pwdata_i[AF_BIT]) begin
        alarm_flag_o <= 1'b0;
      end
    end
  end

  // Interrupt enable bit
  always_ff @(posedge clk_i) begin
    if (rst_i || manual_rst_i) begin
      irq_enable <= CTRL_RST;
    end else if (wr_go && widx == IDX_CTRL) begin
      irq_enable <= pwdata_i[AIE_BIT];
    end
  end

  // Interrupt request follows flag and enable
  always_ff @(posedge clk_i) begin
    if (rst_i || manual_rst_i) begin
      alarm_irq_o <= CTRL_RST;
    end else if (ce_i) begin
      alarm_irq_o <= alarm_flag_o & irq_enable;
    end
  end

  // Read data selection; reserved bits read zero
  always_comb begin
    rd_byte = 8'h00;
    if (widx == IDX_DAY) begin
      rd_byte = day_cnt & DAY_MASK;
    end else if (widx == IDX_MON) begin
      rd_byte = mon_cnt & MON_MASK;
    end else if (widx == IDX_YEAR) begin
      rd_byte = year_cnt;
    end else if (widx == IDX_CTRL) begin
      rd_byte[AF_BIT]  = alarm_flag_o;
      rd_byte[AIE_BIT] = irq_enable;
    end else if (widx != IDX_NONE) begin
      rd_byte = {alm_enb[3'(widx - IDX_ALM0)],
                 alm_val[3'(widx - IDX_ALM0)]};
    end
  end

  // APB answer: one wait state, registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (ce_i) begin
      pready_o  <= acc & ~pready_o;
      if (acc && !pready_o) begin
        prdata_o  <= pwrite_i ? 32'h0000_0000 : {24'h00_0000, rd_byte};
        pslverr_o <= (widx == IDX_NONE);
      end
    end
  end

  // Checks
  sequence s_day_end;
    ce_i && day_tick && day_last && !wr_go;
  endsequence

  property p_day_wrap;
    @(posedge clk_i) disable iff (rst_i)
    s_day_end |=> day_cnt == DAY_FIRST && mon_cnt != $past(mon_cnt);
  endproperty
  a_day_wrap: assert property (p_day_wrap)
    else $error("day did not wrap to 01 with month carry");

  property p_day_step;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && day_tick && !day_last && !wr_go
      |=> day_cnt == bcd_inc($past(day_cnt)) && $stable(mon_cnt);
  endproperty
  a_day_step: assert property (p_day_step)
    else $error("day did not advance by one");

  property p_leap_feb;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && day_tick && !wr_go && mon_cnt == MON_FEB &&
      day_cnt == DAYS_28 && is_leap(year_cnt) |=> day_cnt == DAYS_29;
  endproperty
  a_leap_feb: assert property (p_leap_feb)
    else $error("leap February did not reach 29");

  property p_mon_wrap;
    @(posedge clk_i) disable iff (rst_i)
    s_day_end ##0 mon_cnt == MON_LAST |=> mon_cnt == MON_FIRST;
  endproperty
  a_mon_wrap: assert property (p_mon_wrap)
    else $error("month did not wrap to 01");

  property p_year_wrap;
    @(posedge clk_i) disable iff (rst_i)
    s_day_end ##0 mon_cnt == MON_LAST ##0 year_cnt == YEAR_LAST
      |=> year_cnt == 8'h00;
  endproperty
  a_year_wrap: assert property (p_year_wrap)
    else $error("year did not wrap to 00");

  property p_reset_keeps;
    @(posedge clk_i)
    (&cal_set) && (rst_i || manual_rst_i) && !day_tick && !wr_go
      |=> $stable(day_cnt) && $stable(mon_cnt) && $stable(year_cnt);
  endproperty
  a_reset_keeps: assert property (p_reset_keeps)
    else $error("calendar changed under reset");

  property p_enb_por;
    @(posedge clk_i) rst_i |=> alm_enb == ENB_RST && !alarm_flag_o;
  endproperty
  a_enb_por: assert property (p_enb_por)
    else $error("alarm enables not cleared by reset");

  property p_no_enb;
    @(posedge clk_i) disable iff (rst_i || manual_rst_i)
    ce_i && alm_enb == ENB_RST && !alarm_flag_o |=> !alarm_flag_o;
  endproperty
  a_no_enb: assert property (p_no_enb)
    else $error("flag set with no field enabled");

  property p_flag_set;
    @(posedge clk_i) disable iff (rst_i || manual_rst_i)
    ce_i && match_rise
      |=> alarm_flag_o ##1 (alarm_irq_o == $past(irq_enable));
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("match did not set flag");

  property p_irq;
    @(posedge clk_i) disable iff (rst_i || manual_rst_i)
    ce_i && !alarm_flag_o |=> !alarm_irq_o;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt without alarm flag");

  property p_day_read;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && acc && !pready_o && !pwrite_i && widx == IDX_DAY
      |=> pready_o && prdata_o[7:6] == 2'h0;
  endproperty
  a_day_read: assert property (p_day_read)
    else $error("day read shows bits 7:6 set");

endmodule : rcal_top
`default_nettype wire

// ==== verification/tb_top.sv ====
// Purpose: Self-checking bench for the RTC calendar and alarm block.
// Assumes: APB slave answers with pready_o; ce_i high but for one test.
// Notes:   An integer BCD model predicts counter results; flag checks use fixed values.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import rcal_pkg::*;
  logic        clk_i        = 1'b0;
  logic        rst_i        = 1'b1;
  logic        ce_i         = 1'b1;
  logic        manual_rst_i = 1'b0;
  logic        day_carry_i  = 1'b0;
  logic        count_run_i  = 1'b0;
  logic [7:0]  sec_cnt_i    = 8'h37;
  logic [7:0]  min_cnt_i    = 8'h12;
  logic [7:0]  hr_cnt_i     = 8'h21;
  logic [7:0]  wk_cnt_i     = 8'h05;
  logic        psel_i       = 1'b0;
  logic        penable_i    = 1'b0;
  logic        pwrite_i     = 1'b0;
  logic [7:0]  paddr_i      = 8'h00;
  logic [31:0] pwdata_i     = 32'h0;
  logic        pready_o;
  logic [31:0] prdata_o;
  logic        pslverr_o;
  logic        alarm_flag_o;
  logic        alarm_irq_o;
  logic [31:0] rdata;
  int          failures     = 0;
  int          tests_run    = 0;
  int          seed         = 32'hB2F97486;
  // In-range alarm values
  logic [7:0]  aval [5]     = '{8'h37, 8'h12, 8'h21, 8'h05, 8'h15};
  int          td [6]       = '{28, 29, 28, 30, 31, 15};
  int          tm [6]       = '{2, 2, 2, 4, 12, 6};
  int          ty [6]       = '{0, 4, 1, 7, 99, 42};

  rcal_top dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .manual_rst_i(manual_rst_i), .day_carry_i(day_carry_i),
    .count_run_i(count_run_i), .sec_cnt_i(sec_cnt_i),
    .min_cnt_i(min_cnt_i), .hr_cnt_i(hr_cnt_i), .wk_cnt_i(wk_cnt_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
    .prdata_o(prdata_o), .pslverr_o(pslverr_o),
    .alarm_flag_o(alarm_flag_o), .alarm_irq_o(alarm_irq_o)
  );

  // 40 MHz clock
  always #12.5 clk_i = ~clk_i;

  // Compare one value and count it
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Print counts and verdict, then stop
  task automatic complete_run();
    $display("Counts: %0d checks, %0d mismatches", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  // One APB transfer; holds the request until pready_o is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [7:0] d, input logic err);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= 32'(d);
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 40);
    if (n >= 40) begin
      failures++;
      complete_run();
    end
    rdata = prdata_o;
    chk("pslverr", 32'(pslverr_o), 32'(err));
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 8'h00, 1'b0);
  endtask : rd

  // One day carry from the hours counter, with count-run as given
  task automatic day_step(input logic run);
    @(posedge clk_i);
    count_run_i <= run;
    day_carry_i <= 1'b1;
    @(posedge clk_i);
    day_carry_i <= 1'b0;
    count_run_i <= 1'b0;
  endtask : day_step

  function automatic logic [7:0] i2b(input int v);
    return {4'(v / 10), 4'(v % 10)};
  endfunction : i2b

  // Month length model, leap when year divides by four
  function automatic int mdays(input int m, input int y);
    if (m == 2) return (y % 4 == 0) ? 29 : 28;
    if (m == 4 || m == 6 || m == 9 || m == 11) return 30;
    return 31;
  endfunction : mdays

  // Load a date while count-run is low
  task automatic set_date(input int d, input int m, input int y);
    wr(OFS_DAY, i2b(d));
    wr(OFS_MON, i2b(m));
    wr(OFS_YEAR, i2b(y));
  endtask : set_date

  task automatic chk_date(input int d, input int m, input int y);
    rd(OFS_DAY);
    chk("day", rdata, 32'(i2b(d)));
    rd(OFS_MON);
    chk("month", rdata, 32'(i2b(m)));
    rd(OFS_YEAR);
    chk("year", rdata, 32'(i2b(y)));
  endtask : chk_date

  task automatic settle();
    repeat (3) @(posedge clk_i);
  endtask : settle

  // Watchdog against a hang anywhere
  initial begin
    #2000000;
    failures++;
    complete_run();
  end

  // Main sequence
  initial begin
    int d, m, y, i;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    // Field masks, read-only zeros and refused addresses
    wr(OFS_DAY, 8'hF1);
    rd(OFS_DAY);
    chk("day mask", rdata, 32'h31);
    wr(OFS_MON, 8'hF2);
    rd(OFS_MON);
    chk("month mask", rdata, 32'h12);
    for (i = 0; i < 5; i++) begin
      wr(OFS_ALM0 + 8'(4 * i), aval[i] | {1'b1, ~ALM_MASK[i]});
      rd(OFS_ALM0 + 8'(4 * i));
      chk("alarm mask", rdata, 32'(aval[i] | 8'h80));
    end
    apb(1'b0, 8'h24, 8'h00, 1'b1);
    chk("unmapped read", rdata, 32'h0);
    apb(1'b1, 8'h01, 8'h55, 1'b1);
    $display("Test masks done");
    // Day carries over fixed edge dates, then random dates
    for (i = 0; i < 30; i++) begin
      if (i < 6) begin
        d = td[i];
        m = tm[i];
        y = ty[i];
      end else begin
        y = {$random(seed)} % 100;
        m = {$random(seed)} % 12 + 1;
        d = {$random(seed)} % mdays(m, y) + 1;
        if ({$random(seed)} % 2 == 0) d = mdays(m, y);
      end
      set_date(d, m, y);
      day_step(1'b1);
      d++;
      if (d > mdays(m, y)) begin
        d = 1;
        m++;
      end
      if (m > 12) begin
        m = 1;
        y = (y + 1) % 100;
      end
      chk_date(d, m, y);
    end
    day_step(1'b0);
    chk_date(d, m, y);
    // Clock enable low freezes the counters through a day carry
    ce_i <= 1'b0;
    day_step(1'b1);
    ce_i <= 1'b1;
    chk_date(d, m, y);
    $display("Test calendar done");
    // Values survive both resets; power-on reset drops enables only
    set_date(15, 6, 42);
    for (i = 0; i < 5; i++) wr(OFS_ALM0 + 8'(4 * i), aval[i] | 8'h80);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 5; i++) begin
      rd(OFS_ALM0 + 8'(4 * i));
      chk("alarm after por", rdata, 32'(aval[i]));
      wr(OFS_ALM0 + 8'(4 * i), aval[i] | 8'h80);
    end
    chk_date(15, 6, 42);
    @(posedge clk_i);
    manual_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    manual_rst_i <= 1'b0;
    for (i = 0; i < 5; i++) begin
      rd(OFS_ALM0 + 8'(4 * i));
      chk("alarm after manual", rdata, 32'(aval[i] | 8'h80));
    end
    chk_date(15, 6, 42);
    $display("Test reset done");
    // Each field alone raises the flag when enabled and equal
    for (i = 0; i < 5; i++) begin
      for (d = 0; d < 5; d++) wr(OFS_ALM0 + 8'(4 * d), aval[d] ^ 8'h01);
      wr(OFS_CTRL, 8'h00);
      settle();
      chk("flag cleared", 32'(alarm_flag_o), 32'h0);
      wr(OFS_ALM0 + 8'(4 * i), aval[i] | 8'h80);
      settle();
      chk("flag set", 32'(alarm_flag_o), 32'h1);
    end
    $display("Test compare done");
    // Flag write semantics and interrupt gating
    wr(OFS_CTRL, 8'h09);
    settle();
    chk("flag kept", 32'(alarm_flag_o), 32'h1);
    chk("irq on", 32'(alarm_irq_o), 32'h1);
    wr(OFS_CTRL, 8'h08);
    settle();
    chk("flag off", 32'(alarm_flag_o), 32'h0);
    chk("irq off", 32'(alarm_irq_o), 32'h0);
    wr(OFS_ALM0, (aval[0] ^ 8'h01) | 8'h80);
    settle();
    chk("partial match", 32'(alarm_flag_o), 32'h0);
    sec_cnt_i <= aval[0] ^ 8'h01;
    settle();
    chk("full match", 32'(alarm_flag_o), 32'h1);
    chk("irq again", 32'(alarm_irq_o), 32'h1);
    $display("Test alarm flag done");
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
